// ### hw/ddl_regs.svh
// Purpose: Timing constants for the update latency pipeline of one synthesizer channel.
// Assumes: Counts are in core_sample_clock cycles (clk_sys, 250 MHz).
// Notes: Every latency is counted from the sync-clock edge that samples the trigger.
// Summary of operation
// - Matched latency single-tone: frequency, phase, amplitude appear together 29 cycles after commit.
// - Unmatched single-tone: new frequency word reaches output 29 cycles after commit.
// - Unmatched single-tone: new phase word reaches output 25 cycles after commit.
// - Unmatched single-tone: new amplitude word reaches output 17 cycles after commit.
// - Modulation: frequency 34, phase 29, amplitude 21 cycles after profile change.
// - Sweep: delta effects appear after 41 frequency, 37 phase, 29 amplitude cycles.
// - Single-tone delays count from the commit strobe assertion.
// - Modulation and sweep delays count from a profile-select change.
// - Every delay is fixed and deterministic, no variation between updates.
`ifndef DDL_REGS_SVH
`define DDL_REGS_SVH

// Sync clock is the core clock divided by this ratio
`define DDL_SYNC_DIV 3'd4
`define DDL_SYNC_LAST 2'h3
`define DDL_SYNC_HIGH_END 2'h2

// Delay line length covers the longest path
`define DDL_LINE_DEPTH 41

// Single-tone latencies
`define DDL_LAT_ST_MATCHED 6'd29
`define DDL_LAT_ST_FREQ 6'd29
`define DDL_LAT_ST_PHASE 6'd25
`define DDL_LAT_ST_AMP 6'd17

// Modulation latencies
`define DDL_LAT_MOD_FREQ 6'd34
`define DDL_LAT_MOD_PHASE 6'd29
`define DDL_LAT_MOD_AMP 6'd21

// Linear sweep latencies
`define DDL_LAT_SWP_FREQ 6'd41
`define DDL_LAT_SWP_PHASE 6'd37
`define DDL_LAT_SWP_AMP 6'd29

// Word widths
`define DDL_FREQ_W 32
`define DDL_PHASE_W 14
`define DDL_AMP_W 10
`define DDL_PROF_W 4
`define DDL_TAP_W 6

`endif

// ### hw/ddl_pkg.sv
// Purpose: Types shared by the latency pipeline modules.
// Assumes: ddl_regs.svh supplies widths.
// Notes: Mode codes are one-hot.
`default_nettype none
`include "ddl_regs.svh"
package ddl_pkg;
	typedef enum logic [2:0] {
		DDL_MODE_SINGLE = 3'b001,
		DDL_MODE_MOD = 3'b010,
		DDL_MODE_SWEEP = 3'b100
	} ddl_mode_t;

	typedef logic [`DDL_TAP_W-1:0] ddl_tap_t;
	typedef logic [`DDL_FREQ_W-1:0] ddl_freq_t;
	typedef logic [`DDL_PHASE_W-1:0] ddl_phase_t;
	typedef logic [`DDL_AMP_W-1:0] ddl_amp_t;
	typedef logic [`DDL_PROF_W-1:0] ddl_prof_t;
endpackage
`default_nettype wire

// ### hw/ddl_lane_if.sv
// Purpose: Carries one word lane from the trigger logic into its delay line.
// Assumes: All signals on clk_sys.
// Notes: tap is the delay in cycles; the line ends in an output register.
`default_nettype none
interface ddl_lane_if #(parameter int WIDTH = 8);
	import ddl_pkg::*;
	logic load;
	logic [WIDTH-1:0] word;
	ddl_tap_t delay;
	modport src (output load, output word, output delay);
	modport dst (input load, input word, input delay);
endinterface
`default_nettype wire

// ### hw/ddl_delay_line.sv
// Purpose: Fixed delay from a load pulse to a registered output word and strobe.
// Assumes: delay lies between 1 and DDL_LINE_DEPTH.
// Notes: Stage 0 takes the word on the load edge; output is loaded at load edge + delay.
`default_nettype none
`include "ddl_regs.svh"
module ddl_delay_line
	import ddl_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	ddl_lane_if.dst lane,
	output logic [WIDTH-1:0] out_q,
	output logic out_stb_q
);
	logic [WIDTH-1:0] data_q [`DDL_LINE_DEPTH];
	logic [`DDL_LINE_DEPTH-1:0] vld_q;
	wire [`DDL_TAP_W-1:0] tap_idx = lane.delay - 6'd1;
	wire tap_vld = vld_q[tap_idx];

	// Shift stages; no stall exists, so the delay never varies
	always_ff @(posedge clk_sys) begin
		data_q[0] <= lane.word;
		for (int i = 1; i < `DDL_LINE_DEPTH; i++) begin
			data_q[i] <= data_q[i-1];
		end
		if (reset) begin
			vld_q <= '0;
		end else begin
			vld_q <= {vld_q[`DDL_LINE_DEPTH-2:0], lane.load};
		end
	end

	// Output register holds the last delivered word
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			out_q <= '0;
			out_stb_q <= 1'b0;
		end else begin
			out_stb_q <= tap_vld;
			if (tap_vld) begin
				out_q <= data_q[tap_idx];
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/ddl_update_pipe.sv
// Purpose: Aligns frequency, phase and amplitude changes to fixed output latencies.
// Assumes: Mode, latency select and word inputs come from logic on clk_sys and are stable around triggers.
// Notes: Commit and profile pins are asynchronous and pass a two-flop synchroniser.
`default_nettype none
`include "ddl_regs.svh"
module ddl_update_pipe
	import ddl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire ddl_mode_t mode,
	input wire logic matched_latency_en,
	input wire logic commit_pin,
	input wire ddl_prof_t profile_pin,
	input wire ddl_freq_t tone_freq,
	input wire ddl_phase_t tone_phase,
	input wire ddl_amp_t tone_amp,
	input wire ddl_freq_t prof_freq [16],
	input wire ddl_phase_t prof_phase [16],
	input wire ddl_amp_t prof_amp [16],
	input wire ddl_freq_t sweep_rise_freq,
	input wire ddl_freq_t sweep_fall_freq,
	input wire ddl_phase_t sweep_rise_phase,
	input wire ddl_phase_t sweep_fall_phase,
	input wire ddl_amp_t sweep_rise_amp,
	input wire ddl_amp_t sweep_fall_amp,
	output logic sync_clk_out,
	output logic commit_seen,
	output logic profile_seen,
	output ddl_freq_t dac_freq_q,
	output ddl_phase_t dac_phase_q,
	output ddl_amp_t dac_amp_q,
	output logic dac_freq_stb,
	output logic dac_phase_stb,
	output logic dac_amp_stb
);
	// Sync clock divider
	logic [1:0] div_q;
	logic sync_clk_q;

	// Synchronisers: first stage read only by the second
	logic commit_s1_q;
	logic commit_s2_q;
	ddl_prof_t prof_s1_q;
	ddl_prof_t prof_s2_q;
	// Extra stage so a profile word is taken only once all its bits agree
	ddl_prof_t prof_s3_q;

	// Levels held at the last sync-clock sampling edge
	logic commit_smp_q;
	ddl_prof_t prof_smp_q;

	// Decodes
	wire sync_edge;
	wire prof_steady;
	wire commit_rise;
	wire prof_change;
	wire is_single;
	wire is_mod;
	wire is_sweep;
	wire sweep_rising;
	wire fire;

	// Words chosen for the current trigger
	ddl_freq_t sel_freq;
	ddl_phase_t sel_phase;
	ddl_amp_t sel_amp;
	ddl_tap_t lat_freq;
	ddl_tap_t lat_phase;
	ddl_tap_t lat_amp;

	ddl_lane_if #(.WIDTH(`DDL_FREQ_W)) freq_lane ();
	ddl_lane_if #(.WIDTH(`DDL_PHASE_W)) phase_lane ();
	ddl_lane_if #(.WIDTH(`DDL_AMP_W)) amp_lane ();

	// Divider makes the sync clock; high for the first half of each period
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			div_q <= 2'h0;
			sync_clk_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			// High after the sampling edge and the next one only; after reset the
			// first high waits for the first sampling edge, so no short pulse
			sync_clk_q <= (div_q == `DDL_SYNC_LAST) || ((div_q == 2'h0) && sync_clk_q);
		end
	end

	// Sampling edge is the core edge on which the sync clock rises
	assign sync_edge = (div_q == `DDL_SYNC_LAST);
	assign sync_clk_out = sync_clk_q;

	// Two flops before any logic looks at the pins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			commit_s1_q <= 1'b0;
			commit_s2_q <= 1'b0;
			prof_s1_q <= '0;
			prof_s2_q <= '0;
			prof_s3_q <= '0;
		end else begin
			commit_s1_q <= commit_pin;
			commit_s2_q <= commit_s1_q;
			prof_s1_q <= profile_pin;
			prof_s2_q <= prof_s1_q;
			prof_s3_q <= prof_s2_q;
		end
	end

	// sync-edge sampling
	// Pins are looked at only on sync edges, so a short glitch between them is missed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			commit_smp_q <= 1'b0;
			prof_smp_q <= '0;
		end else if (sync_edge) begin
			commit_smp_q <= commit_s2_q;
			// A profile word still settling is left for the next sync edge
			if (prof_steady) begin
				prof_smp_q <= prof_s2_q;
			end
		end
	end

	// commit strobe assertion
	// A strobe held for one sync period is caught on exactly one sync edge
	assign commit_rise = sync_edge && commit_s2_q && !commit_smp_q;

	// Bits of the profile pins may pass the synchroniser on different edges;
	// a word is trusted only once two successive stages agree, which costs one
	// core cycle of setup but never changes the latency counted from the edge
	assign prof_steady = (prof_s2_q == prof_s3_q);

	assign prof_change = sync_edge && prof_steady && (prof_s2_q != prof_smp_q);

	assign is_single = (mode == DDL_MODE_SINGLE);
	assign is_mod = (mode == DDL_MODE_MOD);
	assign is_sweep = (mode == DDL_MODE_SWEEP);

	// Profile bit 0 picks the rising delta set, low picks falling
	assign sweep_rising = prof_s2_q[0];

	// Only the trigger that the mode counts from starts the pipeline
	assign fire = (is_single && commit_rise) || ((is_mod || is_sweep) && prof_change);
	assign commit_seen = commit_rise;
	assign profile_seen = prof_change;

	// Word selection per mode; the new profile is taken straight from the synchroniser output prof_s2_q, not the sampled level
	always_comb begin
		sel_freq = tone_freq;
		sel_phase = tone_phase;
		sel_amp = tone_amp;
		if (is_mod) begin
			sel_freq = prof_freq[prof_s2_q];
			sel_phase = prof_phase[prof_s2_q];
			sel_amp = prof_amp[prof_s2_q];
		end else if (is_sweep) begin
			sel_freq = sweep_rising ? sweep_rise_freq : sweep_fall_freq;
			sel_phase = sweep_rising ? sweep_rise_phase : sweep_fall_phase;
			sel_amp = sweep_rising ? sweep_rise_amp : sweep_fall_amp;
		end
	end

	// Latency per lane; every value is a constant, so no update differs from the last
	always_comb begin
		lat_freq = `DDL_LAT_ST_FREQ;
		lat_phase = `DDL_LAT_ST_PHASE;
		lat_amp = `DDL_LAT_ST_AMP;
		if (is_single && matched_latency_en) begin
			lat_freq = `DDL_LAT_ST_MATCHED;
			lat_phase = `DDL_LAT_ST_MATCHED;
			lat_amp = `DDL_LAT_ST_MATCHED;
		end else if (is_mod) begin
			lat_freq = `DDL_LAT_MOD_FREQ;
			lat_phase = `DDL_LAT_MOD_PHASE;
			lat_amp = `DDL_LAT_MOD_AMP;
		end else if (is_sweep) begin
			lat_freq = `DDL_LAT_SWP_FREQ;
			lat_phase = `DDL_LAT_SWP_PHASE;
			lat_amp = `DDL_LAT_SWP_AMP;
		end
	end

	// Lane drive: all three lanes load on the same trigger edge
	assign freq_lane.load = fire;
	assign freq_lane.word = sel_freq;
	assign freq_lane.delay = lat_freq;
	assign phase_lane.load = fire;
	assign phase_lane.word = sel_phase;
	assign phase_lane.delay = lat_phase;
	assign amp_lane.load = fire;
	assign amp_lane.word = sel_amp;
	assign amp_lane.delay = lat_amp;

	ddl_delay_line #(.WIDTH(`DDL_FREQ_W)) u_freq_line (
		.clk_sys(clk_sys),
		.reset(reset),
		.lane(freq_lane),
		.out_q(dac_freq_q),
		.out_stb_q(dac_freq_stb)
	);

	ddl_delay_line #(.WIDTH(`DDL_PHASE_W)) u_phase_line (
		.clk_sys(clk_sys),
		.reset(reset),
		.lane(phase_lane),
		.out_q(dac_phase_q),
		.out_stb_q(dac_phase_stb)
	);

	ddl_delay_line #(.WIDTH(`DDL_AMP_W)) u_amp_line (
		.clk_sys(clk_sys),
		.reset(reset),
		.lane(amp_lane),
		.out_q(dac_amp_q),
		.out_stb_q(dac_amp_stb)
	);
endmodule
`default_nettype wire

// ### tb/ddl_checker.sv
// Purpose: Latency checks on the update pipeline ports.
// Assumes: Seen pulses sit in the cycle before the sampling edge.
// Notes: Strobes are sampled one edge after their load edge.
`default_nettype none
module ddl_checker
	import ddl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire ddl_mode_t mode,
	input wire logic matched_latency_en,
	input wire logic sync_clk_out,
	input wire logic commit_seen,
	input wire logic profile_seen,
	input wire ddl_freq_t dac_freq_q,
	input wire logic dac_freq_stb,
	input wire logic dac_phase_stb,
	input wire logic dac_amp_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Triggers count only in the mode that accepts them
	wire logic st_go = commit_seen && mode == DDL_MODE_SINGLE;
	wire logic mod_go = profile_seen && mode == DDL_MODE_MOD;
	wire logic swp_go = profile_seen && mode == DDL_MODE_SWEEP;
	property p_st_match;
		st_go && matched_latency_en |-> ##30 dac_freq_stb && dac_phase_stb && dac_amp_stb;
	endproperty
	a_st_match: assert property (p_st_match) else $error("matched lanes off");
	property p_st_freq;
		st_go && !matched_latency_en |-> ##30 dac_freq_stb;
	endproperty
	a_st_freq: assert property (p_st_freq) else $error("tone freq off");
	property p_st_phase;
		st_go && !matched_latency_en |-> ##26 dac_phase_stb;
	endproperty
	a_st_phase: assert property (p_st_phase) else $error("tone phase off");
	property p_st_amp;
		st_go && !matched_latency_en |-> ##18 dac_amp_stb;
	endproperty
	a_st_amp: assert property (p_st_amp) else $error("tone amp off");
	property p_mod;
		mod_go |-> ##22 dac_amp_stb ##8 dac_phase_stb ##5 dac_freq_stb;
	endproperty
	a_mod: assert property (p_mod) else $error("profile lanes off");
	property p_swp;
		swp_go |-> ##30 dac_amp_stb ##8 dac_phase_stb ##4 dac_freq_stb;
	endproperty
	a_swp: assert property (p_swp) else $error("sweep lanes off");
	// Output word moves only with its strobe
	property p_q_hold;
		$changed(dac_freq_q) |-> dac_freq_stb;
	endproperty
	a_q_hold: assert property (p_q_hold) else $error("freq moved alone");
	property p_seen;
		commit_seen || profile_seen |-> !sync_clk_out ##1 sync_clk_out;
	endproperty
	a_seen: assert property (p_seen) else $error("sample off sync");
	property p_sync;
		$rose(sync_clk_out) |=> sync_clk_out ##1 !sync_clk_out [*2] ##1 sync_clk_out;
	endproperty
	a_sync: assert property (p_sync) else $error("sync period off");
	c_st: cover property (st_go);
	c_mod: cover property (mod_go);
	c_swp: cover property (swp_go);
endmodule
bind ddl_update_pipe ddl_checker ddl_checker_i (.clk_sys, .reset, .mode, .matched_latency_en, .sync_clk_out,
	.commit_seen, .profile_seen, .dac_freq_q, .dac_freq_stb, .dac_phase_stb, .dac_amp_stb);
`default_nettype wire

// ### tb/ddl_host_model.sv
// Purpose: Host driving the commit and profile pins.
// Assumes: Pins change 1 ns after a core edge.
// Notes: Long holds so one sync edge always sees each level.
`default_nettype none
module ddl_host_model
	import ddl_pkg::*;
(
	input wire logic clk_sys,
	output logic commit_pin,
	output ddl_prof_t profile_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		commit_pin = 1'h0;
		profile_pin = 4'h0;
	end
	task automatic commit();
		@(posedge clk_sys);
		#1 commit_pin = 1'h1;
		repeat (8) @(posedge clk_sys);
		#1 commit_pin = 1'h0;
		repeat (8) @(posedge clk_sys);
	endtask
	// Profile held across several sync edges
	task automatic set_profile(input ddl_prof_t p);
		@(posedge clk_sys);
		#1 profile_pin = p;
		repeat (16) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ### tb/ddl_update_pipe_tb.sv
// Purpose: Latency bench for the update pipeline.
// Assumes: Probe counts falling edges; a lane of N shows as N+1.
// Notes: One trigger in flight at a time.
`default_nettype none
module ddl_update_pipe_tb
	import ddl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset, matched, commit_pin, sync_clk_out, commit_seen, profile_seen, f_stb, p_stb, a_stb;
	ddl_mode_t mode;
	ddl_prof_t profile_pin;
	ddl_freq_t tone_freq, sw_rf, sw_ff, dac_freq_q;
	ddl_phase_t tone_phase, sw_rp, sw_fp, dac_phase_q;
	ddl_amp_t tone_amp, sw_ra, sw_fa, dac_amp_q;
	ddl_freq_t prof_freq [16];
	ddl_phase_t prof_phase [16];
	ddl_amp_t prof_amp [16];
	int cyc, t0, lat_f, lat_p, lat_a, n_stb, failures, samples_checked;
	ddl_host_model host_i (.clk_sys(clk_sys), .commit_pin(commit_pin), .profile_pin(profile_pin));
	ddl_update_pipe ddl_update_pipe_i (.clk_sys(clk_sys), .reset(reset), .mode(mode),
		.matched_latency_en(matched), .commit_pin(commit_pin), .profile_pin(profile_pin),
		.tone_freq(tone_freq), .tone_phase(tone_phase), .tone_amp(tone_amp), .prof_freq(prof_freq),
		.prof_phase(prof_phase), .prof_amp(prof_amp), .sweep_rise_freq(sw_rf), .sweep_fall_freq(sw_ff),
		.sweep_rise_phase(sw_rp), .sweep_fall_phase(sw_fp), .sweep_rise_amp(sw_ra), .sweep_fall_amp(sw_fa),
		.sync_clk_out(sync_clk_out), .commit_seen(commit_seen), .profile_seen(profile_seen),
		.dac_freq_q(dac_freq_q), .dac_phase_q(dac_phase_q), .dac_amp_q(dac_amp_q),
		.dac_freq_stb(f_stb), .dac_phase_stb(p_stb), .dac_amp_stb(a_stb));
	task automatic complete_run();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Falling edge probe: combinational pulses have settled; also cuts a hang
	always @(negedge clk_sys) begin
		cyc++;
		if (commit_seen === 1'h1 || profile_seen === 1'h1) t0 = cyc;
		if (f_stb === 1'h1) lat_f = cyc - t0;
		if (p_stb === 1'h1) lat_p = cyc - t0;
		if (a_stb === 1'h1) lat_a = cyc - t0;
		if (f_stb !== 1'h0 || p_stb !== 1'h0 || a_stb !== 1'h0) n_stb++;
		if (cyc > 3000) begin
			failures++;
			complete_run();
		end
	end
	task automatic check_lat(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			failures++;
			$display("Error %0t latency %0d want %0d", $time, got, exp);
		end
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic fire(input logic use_commit, input ddl_prof_t p);
		n_stb = 0;
		// Stale latencies from an earlier trigger would hide a missing strobe
		lat_f = -1;
		lat_p = -1;
		lat_a = -1;
		if (use_commit) host_i.commit();
		else host_i.set_profile(p);
		repeat (40) @(posedge clk_sys);
		#1;
	endtask
	task automatic sc_tone(input logic m, input int ef, input int ep, input int ea);
		matched = m;
		tone_freq = tone_freq + 32'h0101_0101;
		tone_phase = tone_phase + 14'h0123;
		tone_amp = tone_amp + 10'h02B;
		fire(1'h1, 4'h0);
		check_lat(lat_f, ef);
		check_lat(lat_p, ep);
		check_lat(lat_a, ea);
		check_word(dac_freq_q, tone_freq);
		check_word(32'(dac_phase_q), 32'(tone_phase));
		check_word(32'(dac_amp_q), 32'(tone_amp));
	endtask
	task automatic sc_mod();
		mode = DDL_MODE_MOD;
		fire(1'h0, 4'h5);
		check_lat(lat_f, 35);
		check_lat(lat_p, 30);
		check_lat(lat_a, 22);
		check_word(dac_freq_q, prof_freq[5]);
		check_word(32'(dac_phase_q), 32'(prof_phase[5]));
		check_word(32'(dac_amp_q), 32'(prof_amp[5]));
	endtask
	task automatic sc_sweep();
		mode = DDL_MODE_SWEEP;
		fire(1'h0, 4'h6);
		check_word(dac_freq_q, sw_ff);
		fire(1'h0, 4'h7);
		check_lat(lat_f, 42);
		check_lat(lat_p, 38);
		check_lat(lat_a, 30);
		check_word(32'(dac_phase_q), 32'(sw_rp));
	endtask
	task automatic sc_refused();
		fire(1'h1, 4'h0);
		check_lat(n_stb, 0);
		mode = DDL_MODE_SINGLE;
		fire(1'h0, 4'h9);
		check_lat(n_stb, 0);
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		{reset, matched, mode} = {1'h1, 1'h1, DDL_MODE_SINGLE};
		{tone_freq, tone_phase, tone_amp} = '0;
		{sw_rf, sw_ff, sw_rp, sw_fp, sw_ra, sw_fa} = {32'hA5A5_0001, 32'h5A5A_0002, 14'h1111, 14'h2222, 10'h111, 10'h222};
		for (int i = 0; i < 16; i++) begin
			{prof_freq[i], prof_phase[i], prof_amp[i]} = {32'h1000_0000 + i, 14'h0200 + 14'(i), 10'h040 + 10'(i)};
		end
		repeat (12) @(posedge clk_sys);
		#1 reset = 1'h0;
		sc_tone(1'h1, 30, 30, 30);
		sc_tone(1'h1, 30, 30, 30);
		sc_tone(1'h0, 30, 26, 18);
		sc_mod();
		sc_sweep();
		sc_refused();
		complete_run();
	end
endmodule
`default_nettype wire
